// File: pkg/cmp_pkg.sv
/*
 * Types for the configuration management port.
 * Assumes cmp_regs.svh is on the include path.
 */
`include "cmp_regs.svh"

package cmp_pkg;

    typedef enum logic [1:0] {
        CMP_IDLE,
        CMP_BUSY,
        CMP_DONE
    } cmp_state_type;

    typedef struct packed {
        cmp_state_type state;
        logic is_write;
        logic [`CMP_REG_IDX_W-1:0] reg_idx;
        logic [$clog2(`CMP_PF_NUM*(`CMP_VF_PER_PF+1))-1:0] fn_idx;
        logic hit;
        logic ack;
        logic [`CMP_DATA_W-1:0] dout;
    } cmp_ctl_type;

endpackage : cmp_pkg

// File: pkg/cmp_regs.svh
/*
 * Constants for the configuration management port: address layout,
 * register counts, reset values and timing.
 * Assumes it is included by its bare name from package or module scope.
 */
`ifndef CMP_REGS_SVH
`define CMP_REGS_SVH

`define CMP_ADDR_W 12
`define CMP_WORD_LSB 2
`define CMP_WORD_W 10
`define CMP_DATA_W 32
`define CMP_PF_NUM 2
`define CMP_PF_SEL_W 1
`define CMP_VF_PER_PF 4
`define CMP_VF_OFS_W 11
`define CMP_REGS_PER_FN 16
`define CMP_REG_IDX_W 4
`define CMP_DATA_RST 32'h00000000
`define CMP_MASK_RO 32'h00000000
`define CMP_MASK_CTL 32'h0000FFFF
`define CMP_MASK_LOG 32'hFFFFFFFF
`define CMP_ACK_LATENCY 2

`endif

// File: src/cmp_mgmt_port.sv
/*
 * Configuration register bank with local management port: holds a small
 * configuration space per physical and virtual function and serves reads
 * and writes with a one-cycle acknowledge.
 * Assumes the master is logic on clk and keeps one request open at a time.
 */
`timescale 1ns/1ns

// Contract
// - After a read or write completes the port pulses its acknowledge high for exactly one cycle.
// - Read data is shown on the 32-bit data output in the cycle acknowledge is high for a read.
// - A write changes only writable bits of the target register and leaves read-only bits alone.
// - Every register can be read while only read-write fields can be written.
// - The port reaches registers of both physical and virtual functions by the selection inputs.
module cmp_mgmt_port
    import cmp_pkg::*;
#(
    parameter int PF_NUM = `CMP_PF_NUM,
    parameter int VF_PER_PF = `CMP_VF_PER_PF,
    parameter int REGS_PER_FN = `CMP_REGS_PER_FN
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic mgmt_rd_en,
    input wire logic mgmt_wr_en,
    input wire logic [`CMP_ADDR_W-1:0] mgmt_addr,
    input wire logic [`CMP_PF_SEL_W-1:0] mgmt_phys_func_sel,
    input wire logic mgmt_virt_func_flag,
    input wire logic [`CMP_VF_OFS_W-1:0] mgmt_virt_func_offset,
    input wire logic [`CMP_DATA_W-1:0] mgmt_din,
    output logic [`CMP_DATA_W-1:0] mgmt_dout,
    output logic mgmt_ack
);
    localparam int FN_NUM = PF_NUM * (VF_PER_PF + 1);
    localparam int FN_W = $clog2(FN_NUM);

    // writable-bit mask per register index; id/status words stay read-only,
    // header log words take any value, the control word only its low half
    function automatic logic [`CMP_DATA_W-1:0] wr_mask(input logic [`CMP_REG_IDX_W-1:0] idx);
        logic [`CMP_DATA_W-1:0] m;
        m = `CMP_MASK_RO;
        unique case (idx)
            4'h0: m = `CMP_MASK_RO;
            4'h1: m = `CMP_MASK_CTL;
            4'h2: m = `CMP_MASK_RO;
            4'h3: m = `CMP_MASK_RO;
            4'h4: m = `CMP_MASK_RO;
            4'h5: m = `CMP_MASK_RO;
            4'h6: m = `CMP_MASK_RO;
            4'h7: m = `CMP_MASK_RO;
            4'h8: m = `CMP_MASK_LOG;
            4'h9: m = `CMP_MASK_LOG;
            4'hA: m = `CMP_MASK_LOG;
            4'hB: m = `CMP_MASK_LOG;
            4'hC: m = `CMP_MASK_LOG;
            4'hD: m = `CMP_MASK_LOG;
            4'hE: m = `CMP_MASK_LOG;
            4'hF: m = `CMP_MASK_LOG;
        endcase
        return m;
    endfunction : wr_mask

    // selection names an existing pf, and for a vf an offset inside its set
    function automatic logic sel_hit(input logic [`CMP_PF_SEL_W-1:0] pf, input logic vf,
                                     input logic [`CMP_VF_OFS_W-1:0] ofs);
        logic ok;
        // compared at 32 bits; casting the count to the select width would wrap it
        ok = 32'(pf) < 32'(PF_NUM);
        if (vf && (32'(ofs) >= 32'(VF_PER_PF))) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : sel_hit

    // bytes above one function's register block miss
    function automatic logic addr_hit(input logic [`CMP_ADDR_W-1:0] addr);
        return addr[`CMP_ADDR_W-1:`CMP_WORD_LSB+`CMP_REG_IDX_W] == '0;
    endfunction : addr_hit

    // flat function index: physical functions first, then each pf's vf block
    function automatic logic [FN_W-1:0] fn_index(input logic [`CMP_PF_SEL_W-1:0] pf, input logic vf,
                                                 input logic [`CMP_VF_OFS_W-1:0] ofs);
        logic [31:0] i;
        i = 32'(pf);
        if (vf) begin
            i = 32'(PF_NUM) + 32'(pf) * 32'(VF_PER_PF) + 32'(ofs);
        end
        return FN_W'(i);
    endfunction : fn_index

    cmp_ctl_type ctl_q;
    cmp_ctl_type ctl_d;
    logic [`CMP_DATA_W-1:0] cfg_q [FN_NUM][REGS_PER_FN];
    logic hit_c;
    logic wr_go;

    // out-of-range selections answer zero and write nothing
    assign hit_c = sel_hit(mgmt_phys_func_sel, mgmt_virt_func_flag, mgmt_virt_func_offset)
        && addr_hit(mgmt_addr);

    // write lands at the edge ending the busy cycle, din still held
    assign wr_go = (ctl_q.state == CMP_BUSY) && ctl_q.is_write && ctl_q.hit;

    always_comb begin
        ctl_d = ctl_q;
        ctl_d.ack = 1'b0;
        unique case (ctl_q.state)
            CMP_IDLE: begin
                if (mgmt_rd_en || mgmt_wr_en) begin
                    // word index from byte address, low bits dropped
                    ctl_d.reg_idx = mgmt_addr[`CMP_WORD_LSB +: `CMP_REG_IDX_W];
                    ctl_d.fn_idx = fn_index(mgmt_phys_func_sel, mgmt_virt_func_flag, mgmt_virt_func_offset);
                    ctl_d.hit = hit_c;
                    // write wins if both raised; master should not do that
                    ctl_d.is_write = mgmt_wr_en;
                    ctl_d.state = CMP_BUSY;
                end
            end
            CMP_BUSY: begin
                // read data lands with the ack
                ctl_d.dout = ctl_q.hit ? cfg_q[ctl_q.fn_idx][ctl_q.reg_idx] : `CMP_DATA_RST;
                ctl_d.ack = 1'b1;
                ctl_d.state = CMP_DONE;
            end
            CMP_DONE: begin
                // one idle cycle lets the master drop its enable
                ctl_d.state = CMP_IDLE;
            end
            default: begin
                ctl_d.state = CMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_q <= '{
                state: CMP_IDLE,
                is_write: 1'b0,
                reg_idx: '0,
                fn_idx: '0,
                hit: 1'b0,
                ack: 1'b0,
                dout: `CMP_DATA_RST
            };
        end else begin
            ctl_q <= ctl_d;
        end
    end

    genvar gf;
    genvar gr;
    generate
        for (gf = 0; gf < FN_NUM; gf++) begin : g_fn
            for (gr = 0; gr < REGS_PER_FN; gr++) begin : g_reg
                logic cell_sel;
                assign cell_sel = wr_go && (ctl_q.fn_idx == FN_W'(gf)) && (ctl_q.reg_idx == `CMP_REG_IDX_W'(gr));
                always_ff @(posedge clk or negedge nrst) begin
                    if (!nrst) begin
                        cfg_q[gf][gr] <= `CMP_DATA_RST;
                    end else if (cell_sel) begin
                        // read-only bits kept, writable bits replaced
                        // reads unrestricted, writes masked to rw fields
                        cfg_q[gf][gr] <= (cfg_q[gf][gr] & ~wr_mask(`CMP_REG_IDX_W'(gr)))
                            | (mgmt_din & wr_mask(`CMP_REG_IDX_W'(gr)));
                    end
                end
            end
        end
    endgenerate

    assign mgmt_dout = ctl_q.dout;
    assign mgmt_ack = ctl_q.ack;

endmodule : cmp_mgmt_port

// File: tb/cmp_master_model.sv
/* management master model; assumes ack and dout from the port on clk */
`timescale 1ns/1ns
module cmp_master_model (
    input wire logic clk,
    input wire logic mgmt_ack,
    input wire logic [31:0] mgmt_dout,
    output logic mgmt_rd_en,
    output logic mgmt_wr_en,
    output logic [11:0] mgmt_addr,
    output logic [0:0] mgmt_phys_func_sel,
    output logic mgmt_virt_func_flag,
    output logic [10:0] mgmt_virt_func_offset,
    output logic [31:0] mgmt_din
);
    initial {mgmt_rd_en, mgmt_wr_en, mgmt_addr, mgmt_phys_func_sel, mgmt_virt_func_flag} = '0;
    initial {mgmt_virt_func_offset, mgmt_din} = '0;
    task xfer(input logic w, input logic [11:0] a, input logic p, v, input logic [10:0] o,
        input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        {mgmt_rd_en, mgmt_wr_en, mgmt_addr, mgmt_din} = {!w, w, a, d};
        {mgmt_phys_func_sel, mgmt_virt_func_flag, mgmt_virt_func_offset} = {p, v, o};
        // held until ack seen; a hang runs into the bench's cycle ceiling
        do begin
            @(negedge clk);
        end while (mgmt_ack !== 1'b1);
        q = mgmt_dout;
        @(negedge clk);
        // released address and data lines show inverse, not stale values; enables drop to zero, selection lines keep their values
        {mgmt_rd_en, mgmt_wr_en, mgmt_addr, mgmt_din} = {2'h0, ~a, ~d};
    endtask : xfer
endmodule : cmp_master_model

// File: tb/cmp_mgmt_port_assertions.sv
/* pin checks on the management port; assumes one clock, nrst active low */
`timescale 1ns/1ns
module cmp_mgmt_port_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire logic mgmt_rd_en,
    input wire logic mgmt_wr_en,
    input wire logic [31:0] mgmt_dout,
    input wire logic mgmt_ack
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_take;
        $rose(mgmt_rd_en || mgmt_wr_en);
    endsequence
    sequence s_answer;
        !mgmt_ack [*2] ##1 mgmt_ack;
    endsequence
    chk_ack_latency: assert property (s_take |-> s_answer) else $error("ack latency wrong");
    chk_ack_single: assert property (mgmt_ack |=> !mgmt_ack) else $error("ack too long");
    chk_ack_cause: assert property ($rose(mgmt_ack) |-> $past(mgmt_rd_en || mgmt_wr_en, 2))
        else $error("ack without request");
    chk_ack_spacing: assert property (mgmt_ack |=> !mgmt_ack [*2]) else $error("acks too close");
    chk_dout_hold: assert property ($changed(mgmt_dout) |-> mgmt_ack) else $error("dout moved off ack");
endmodule : cmp_mgmt_port_assertions
bind cmp_mgmt_port cmp_mgmt_port_assertions i_chk (.clk(clk), .nrst(nrst), .mgmt_rd_en(mgmt_rd_en),
    .mgmt_wr_en(mgmt_wr_en), .mgmt_dout(mgmt_dout), .mgmt_ack(mgmt_ack));

// File: tb/cmp_mgmt_port_test.sv
/* bench for the management port; assumes the master model drives the port */
`timescale 1ns/1ns
module cmp_mgmt_port_test;
    logic clk, nrst, rd, wr, vf, ack;
    logic [11:0] addr;
    logic [0:0] pf;
    logic [10:0] ofs;
    logic [31:0] din, dout, q;
    int error_cnt = 0, checks = 0, cyc = 0;
    cmp_mgmt_port i_cmp_mgmt_port (.clk(clk), .nrst(nrst), .mgmt_rd_en(rd), .mgmt_wr_en(wr), .mgmt_addr(addr),
        .mgmt_phys_func_sel(pf), .mgmt_virt_func_flag(vf), .mgmt_virt_func_offset(ofs), .mgmt_din(din),
        .mgmt_dout(dout), .mgmt_ack(ack));
    cmp_master_model i_cmp_master_model (.clk(clk), .mgmt_ack(ack), .mgmt_dout(dout), .mgmt_rd_en(rd),
        .mgmt_wr_en(wr), .mgmt_addr(addr), .mgmt_phys_func_sel(pf), .mgmt_virt_func_flag(vf),
        .mgmt_virt_func_offset(ofs), .mgmt_din(din));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task close_out;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    // generous: all three tests need a few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            close_out();
        end
    end
    task chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task rw(input logic w, input logic [11:0] a, input logic p, v, input logic [10:0] o, input logic [31:0] d);
        i_cmp_master_model.xfer(w, a, p, v, o, d, q);
    endtask : rw
    task t_masks;
        rw(1'h0, 12'h020, 1'h0, 1'h0, 11'h0, 32'h0);
        chk("reset value", q, 32'h0);
        for (int r = 0; r < 16; r++) rw(1'h1, 12'(r * 4), 1'h0, 1'h0, 11'h0, 32'hFFFFFFFF);
        for (int r = 0; r < 16; r++) begin
            rw(1'h0, 12'(r * 4 + 3), 1'h0, 1'h0, 11'h0, 32'h0);
            chk("masked reg", q, r == 1 ? 32'h0000FFFF : (r >= 8 ? 32'hFFFFFFFF : 32'h0));
        end
        $display("test masks done");
    endtask : t_masks
    task t_funcs;
        for (int i = 0; i < 6; i++) rw(1'h1, 12'h024, i[0], i > 1, i > 3 ? 11'h3 : 11'h0, {28'hA5A5A5A, 4'(i)});
        for (int i = 0; i < 6; i++) begin
            rw(1'h0, 12'h024, i[0], i > 1, i > 3 ? 11'h3 : 11'h0, 32'h0);
            chk("function reg", q, {28'hA5A5A5A, 4'(i)});
        end
        $display("test functions done");
    endtask : t_funcs
    task t_miss;
        // deliberate offset past the vf set would alias pf1 vf0
        rw(1'h1, 12'h024, 1'h0, 1'h1, 11'h4, 32'h0);
        rw(1'h0, 12'h024, 1'h1, 1'h1, 11'h0, 32'h0);
        chk("vf offset write miss", q, 32'hA5A5A5A3);
        rw(1'h0, 12'h024, 1'h0, 1'h1, 11'h4, 32'h0);
        chk("vf offset read miss", q, 32'h0);
        // high address bits set would alias register 9 of pf0
        rw(1'h1, 12'h064, 1'h0, 1'h0, 11'h0, 32'h0);
        rw(1'h0, 12'h024, 1'h0, 1'h0, 11'h0, 32'h0);
        chk("high addr write miss", q, 32'hA5A5A5A0);
        rw(1'h0, 12'h064, 1'h0, 1'h0, 11'h0, 32'h0);
        chk("high addr read miss", q, 32'h0);
        $display("test misses done");
    endtask : t_miss
    initial begin
        nrst = 1'h0;
        repeat (6) @(negedge clk);
        nrst = 1'h1;
        t_masks();
        t_funcs();
        t_miss();
        close_out();
    end
endmodule : cmp_mgmt_port_test
